// [include/mik_pkg.sv]
// constants, carrier structs and enumerations for the beacon ident keyer
// Behaviour
// - 64-bit code memory, non-destructive repeated readout
// - 256-state counter, six bits address memory
// - full memory pass about 7.5 seconds
// - read mode clock free-runs near 8.5 Hz
// - every keying clock advances address by one
// - each clock period strobes memory at address
// - stored one emits 50 us pulse, sets flip-flop
// - mark drives keying relay and mark lamp
// - next clock first resets keying flip-flop
// - one-pulse follows strobe trailing edge, sets again
// - stored zero: no pulse, relay released
// - space lamp on for zero, never with mark
// - test or unreliability makes whole memory accessible
// - remote, normal, no fault: suppress 16 bits
// - remote fault enables suppressed error region
// - zero presses until error lamp, then unreliability
// - error lamp out after 16-bit region passed
// - unreliability off sends ident only
// - keying inhibited 192 of 256 counter states
// - reset button returns counter, memory kept
// - entry: oscillator stops, press steps and writes
// - co-sited gate active only in code period
package mik_pkg;

    // ****************************************
    // clock and timing
    // ****************************************
    localparam longint CLK_HZ        = 10_000_000;        // hclk rate
    localparam longint KEY_RATE_MHZ  = 8_500;             // keying clock, millihertz
    localparam longint KEY_PERIOD_CYC = (CLK_HZ * 1000) / KEY_RATE_MHZ; // one dot
    localparam longint STROBE_US     = 50;                // memory strobe width
    localparam int     STROBE_CYC    = int'((STROBE_US * CLK_HZ + 999_999) / 1_000_000);
    localparam longint MEM_PULSE_US  = 50;                // memory one-pulse width
    localparam int     MEM_PULSE_CYC = int'((MEM_PULSE_US * CLK_HZ + 999_999) / 1_000_000);
    localparam longint DEBOUNCE_MS   = 10;                // button settle time
    localparam longint DEBOUNCE_CYC  = (DEBOUNCE_MS * CLK_HZ) / 1000;

    // ****************************************
    // register map (byte offsets) and fields
    // ****************************************
    localparam logic [7:0] REG_CTRL   = 8'h00;            // mode switches
    localparam logic [7:0] REG_SPEED  = 8'h04;            // dot length in cycles
    localparam logic [7:0] REG_STATUS = 8'h08;            // read-only state
    localparam int CTRL_ENTRY   = 0;                      // entry_read_switch: 1 = entry
    localparam int CTRL_ERRTEST = 1;                      // error_source_switch: 1 = test
    localparam int CTRL_UNREL   = 2;                      // unreliability_select on
    localparam logic [2:0]  CTRL_RESET  = 3'h0;           // read, remote, normal
    localparam int          SPEED_W     = 24;             // speed field width
    localparam int ST_KEY   = 8;                          // status: keying flip-flop
    localparam int ST_SPACE = 9;                          // status: space lamp
    localparam int ST_ERR   = 10;                         // status: error lamp
    localparam int ST_GATE  = 11;                         // status: co-sited gate
    localparam int ST_BUSY  = 12;                         // status: strobe cycle running

    // ****************************************
    // code memory geometry
    // ****************************************
    localparam int         MEM_BITS  = 64;                // code memory depth
    localparam int         MEM_AW    = 6;                 // memory address width
    localparam int         CNT_W     = 8;                 // 256-state counter
    localparam logic [1:0] ERR_REGION = 2'h3;             // bits 48..63
    localparam int         NBTN      = 3;                 // one, zero, reset buttons
    localparam int         BTN_ONE   = 0;
    localparam int         BTN_ZERO  = 1;
    localparam int         BTN_RST   = 2;

    // ****************************************
    // carriers and states
    // ****************************************
    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic        hready;
        logic [31:0] hwdata;
    } mik_ahb_req_t;

    typedef struct packed {
        logic        hreadyout;
        logic        hresp;
        logic [31:0] hrdata;
    } mik_ahb_rsp_t;

    typedef struct packed {
        logic keying_relay;
        logic mark_lamp;
        logic space_lamp;
        logic error_lamp;
        logic colocated_gate_relay;
    } mik_key_out_t;

    // strobe sequence, gray along idle -> strobe -> pulse; pulse -> idle flips both bits
    typedef enum logic [1:0] {
        SEQ_IDLE   = 2'b00,
        SEQ_STROBE = 2'b01,
        SEQ_PULSE  = 2'b11
    } mik_seq_t;

endpackage

// [verilog/mik_debounce.sv]
// button synchroniser and debouncer giving one pulse per press
`timescale 1ns/10ps
module mik_debounce
    import mik_pkg::*;
#(
    parameter logic [23:0] SETTLE_CYC = 24'(DEBOUNCE_CYC)
)
(
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic button_raw,
    output logic      press_pulse
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic        sync1;   // first stage, read only by sync2
        logic        sync2;   // synchronised level
        logic        stable;  // accepted level
        logic [23:0] cnt;     // settle counter
        logic        pulse;   // one-cycle press
    } mik_deb_state_t;

    mik_deb_state_t st_ff;    // registered state
    mik_deb_state_t nxt_st;   // next state

    // settle timer: level must hold SETTLE_CYC before it is accepted
    always_comb
    begin
        nxt_st       = st_ff;
        nxt_st.sync1 = button_raw;
        nxt_st.sync2 = st_ff.sync1;
        nxt_st.pulse = 1'b0;
        if (st_ff.sync2 == st_ff.stable)
        begin
            // contact bounce restarts the wait
            nxt_st.cnt = 24'h0;
        end
        else if (st_ff.cnt >= SETTLE_CYC - 24'h1)
        begin
            nxt_st.cnt    = 24'h0;
            nxt_st.stable = st_ff.sync2;
            nxt_st.pulse  = st_ff.sync2;
        end
        else
        begin
            nxt_st.cnt = st_ff.cnt + 24'h1;
        end
    end

    // state register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign press_pulse = st_ff.pulse;

endmodule

// [verilog/mik_code_mem.sv]
// 64 x 1 read/write code memory with registered read data
`timescale 1ns/10ps
module mik_code_mem
    import mik_pkg::*;
(
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic [MEM_AW-1:0] addr,
    input  wire logic              we,
    input  wire logic              wdata,
    output logic                   rdata
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [MEM_BITS-1:0] bits;  // stored message
        logic                rd;    // read register
    } mik_mem_state_t;

    mik_mem_state_t st_ff;          // registered state
    mik_mem_state_t nxt_st;         // next state

    // reads never disturb the stored bits
    always_comb
    begin
        nxt_st    = st_ff;
        nxt_st.rd = st_ff.bits[addr];
        if (we)
            nxt_st.bits[addr] = wdata;
    end

    // state register; hresetn stands in for a flat battery
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign rdata = st_ff.rd;

endmodule

// [verilog/mik_keyer.sv]
// beacon identification keyer: oscillator, counter, gating, keying and AHB-Lite registers
`timescale 1ns/10ps
module mik_keyer
    import mik_pkg::*;
#(
    parameter logic [SPEED_W-1:0] KEY_PERIOD = SPEED_W'(KEY_PERIOD_CYC), // dot in cycles
    parameter logic [23:0]        SETTLE     = 24'(DEBOUNCE_CYC)         // button settle
)
(
    input  wire logic   hclk,
    input  wire logic   hresetn,
    input  mik_ahb_req_t ahb_req,
    output mik_ahb_rsp_t ahb_rsp,
    // far side: operator buttons, remote fault line, relays and lamps
    input  wire logic   one_button,
    input  wire logic   zero_button,
    input  wire logic   address_reset_button,
    input  wire logic   remote_fault,
    output mik_key_out_t key_out
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        // software switches
        logic               entry_mode;   // entry_read_switch
        logic               err_test;     // error_source_switch at test
        logic               unrel_on;     // unreliability_select
        logic [SPEED_W-1:0] speed;        // keying_oscillator period
        // bus data phase
        logic               wr_pend;      // write data due this cycle
        logic [7:0]         wr_addr;      // offset of pending write
        logic [31:0]        hrdata;       // read data register
        logic               hreadyout;    // always ready after reset
        logic               hresp;        // response code, always okay
        // keying core
        logic [CNT_W-1:0]   addr;         // address_counter
        logic [SPEED_W-1:0] osc_cnt;      // keying_oscillator phase
        mik_seq_t           seq;          // strobe sequence
        logic [9:0]         seq_cnt;      // cycles left in phase
        logic               wr_entry;     // this strobe writes
        logic               wr_bit;       // value to write
        logic               keying;       // keying_flipflop
        // registered outputs
        mik_key_out_t       outs;
    } mik_key_state_t;

    mik_key_state_t st_ff;                // registered state
    mik_key_state_t nxt_st;               // next state

    // ****************************************
    // buttons
    // ****************************************
    logic [NBTN-1:0] btn_raw;             // raw button levels
    logic [NBTN-1:0] btn_press;           // one pulse per press

    assign btn_raw[BTN_ONE]  = one_button;
    assign btn_raw[BTN_ZERO] = zero_button;
    assign btn_raw[BTN_RST]  = address_reset_button;

    // one debouncer per button; a press shorter than the settle
    // time is ignored, which also rejects contact bounce
    genvar gi;
    generate
        for (gi = 0; gi < NBTN; gi++)
        begin : g_btn
            mik_debounce #(
                .SETTLE_CYC  (SETTLE)
            ) u_deb (
                .hclk        (hclk),
                .hresetn     (hresetn),
                .button_raw  (btn_raw[gi]),
                .press_pulse (btn_press[gi])
            );
        end
    endgenerate

    // ****************************************
    // code memory
    // ****************************************
    logic mem_we;                          // write strobe
    logic mem_rdata;                       // registered bit at address

    // cleared only by hresetn, never by the address reset button,
    // so the message survives a restart of the count
    mik_code_mem u_mem (
        .hclk    (hclk),
        .hresetn (hresetn),
        .addr    (st_ff.addr[MEM_AW-1:0]),
        .we      (mem_we),
        .wdata   (st_ff.wr_bit),
        .rdata   (mem_rdata)
    );

    // ****************************************
    // gating
    // ****************************************
    logic code_window;                     // counter in the 64-state code period
    logic err_region;                      // bits 48..63 of the memory
    logic err_enable;                      // error region opened
    logic access_en;                       // memory enable

    // one decode serves memory enable, lamps and co-sited gate, so
    // the other station cannot send its ident while this one keys

    always_comb
    begin
        code_window = (st_ff.addr[CNT_W-1:MEM_AW] == 2'h0);
        err_region  = (st_ff.addr[MEM_AW-1:MEM_AW-2] == ERR_REGION);
        err_enable  = st_ff.err_test | st_ff.unrel_on | remote_fault;
        access_en   = code_window & (err_enable | ~err_region);
    end

    // ****************************************
    // bus decode
    // ****************************************
    logic        bus_take;                 // address phase accepted
    logic [7:0]  bus_off;                  // low address bits
    logic [31:0] rd_mux;                   // read value at bus_off
    logic [31:0] status_word;              // live state

    always_comb
    begin
        // zero wait states: every data phase ends at the next edge
        bus_take = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready;
        bus_off  = ahb_req.haddr[7:0];
        // status is a live snapshot; bits above 12 read zero
        status_word = 32'h0;
        status_word[CNT_W-1:0] = st_ff.addr;
        status_word[ST_KEY]    = st_ff.keying;
        status_word[ST_SPACE]  = st_ff.outs.space_lamp;
        status_word[ST_ERR]    = st_ff.outs.error_lamp;
        status_word[ST_GATE]   = st_ff.outs.colocated_gate_relay;
        status_word[ST_BUSY]   = (st_ff.seq != SEQ_IDLE);
        // unmapped words read as zero
        // a read right after a write to the same word sees the old value
        if (bus_off == REG_CTRL)
            rd_mux = {29'h0, st_ff.unrel_on, st_ff.err_test, st_ff.entry_mode};
        else if (bus_off == REG_SPEED)
            rd_mux = {8'h0, st_ff.speed};
        else if (bus_off == REG_STATUS)
            rd_mux = status_word;
        else
            rd_mux = 32'h0;
    end

    // ****************************************
    // next state
    // ****************************************
    // tick is the keying clock; in entry mode a press makes it
    logic tick;                            // keying clock pulse
    logic tick_wr;                         // tick comes from an entry press
    logic hit;                             // memory emits a one-pulse

    always_comb
    begin
        nxt_st = st_ff;
        mem_we = 1'b0;
        tick   = 1'b0;
        tick_wr = 1'b0;
        hit    = 1'b0;

        // bus address phase: sample read data, remember writes
        nxt_st.hreadyout = 1'b1;
        // no error response: every offset answers okay
        nxt_st.hresp     = 1'b0;
        nxt_st.wr_pend   = bus_take & ahb_req.hwrite;
        nxt_st.wr_addr   = bus_off;
        if (bus_take & ~ahb_req.hwrite)
            nxt_st.hrdata = rd_mux;

        // bus data phase: writes to read-only or unmapped words are dropped
        if (st_ff.wr_pend)
        begin
            if (st_ff.wr_addr == REG_CTRL)
            begin
                nxt_st.entry_mode = ahb_req.hwdata[CTRL_ENTRY];
                nxt_st.err_test   = ahb_req.hwdata[CTRL_ERRTEST];
                nxt_st.unrel_on   = ahb_req.hwdata[CTRL_UNREL];
            end
            else if (st_ff.wr_addr == REG_SPEED)
            begin
                // speed setting adjusts rate
                // a speed below one sequence length makes ticks wait
                nxt_st.speed = ahb_req.hwdata[SPEED_W-1:0];
            end
        end

        // keying oscillator
        // the count is cleared, not held, in entry mode, so the first
        // read tick after entry comes one full period later
        if (st_ff.entry_mode)
        begin
            nxt_st.osc_cnt = '0;
            if (st_ff.seq == SEQ_IDLE && (btn_press[BTN_ONE] | btn_press[BTN_ZERO]))
            begin
                tick    = 1'b1;
                tick_wr = 1'b1;
            end
        end
        else if (st_ff.osc_cnt >= st_ff.speed - SPEED_W'(1))
        begin
            // free-running keying clock
            // a tick waits if the previous strobe cycle has not finished
            if (st_ff.seq == SEQ_IDLE)
            begin
                tick           = 1'b1;
                nxt_st.osc_cnt = '0;
            end
        end
        else
        begin
            nxt_st.osc_cnt = st_ff.osc_cnt + SPEED_W'(1);
        end

        // strobe sequence
        // a press that arrives while the sequence runs is lost, so
        // presses must be spaced by more than strobe plus pulse
        case (st_ff.seq)
            SEQ_IDLE:
            begin
                if (tick)
                begin
                    nxt_st.addr     = st_ff.addr + CNT_W'(1);
                    nxt_st.keying   = 1'b0;
                    nxt_st.seq      = SEQ_STROBE;
                    nxt_st.seq_cnt  = 10'(STROBE_CYC - 1);
                    nxt_st.wr_entry = tick_wr;
                    nxt_st.wr_bit   = btn_press[BTN_ONE];
                end
            end
            SEQ_STROBE:
            begin
                if (st_ff.seq_cnt != 10'h0)
                begin
                    nxt_st.seq_cnt = st_ff.seq_cnt - 10'h1;
                end
                else
                begin
                    // trailing edge of strobe: write, then read out
                    // a written one is keyed at once, echoing the entry
                    // write only where memory enabled
                    mem_we = st_ff.wr_entry & access_en;
                    hit    = access_en & (st_ff.wr_entry ? st_ff.wr_bit : mem_rdata);
                    nxt_st.wr_entry = 1'b0;
                    if (hit)
                    begin
                        nxt_st.keying  = 1'b1;
                        nxt_st.seq     = SEQ_PULSE;
                        nxt_st.seq_cnt = 10'(MEM_PULSE_CYC - 1);
                    end
                    else
                    begin
                        nxt_st.seq = SEQ_IDLE;
                    end
                end
            end
            // internal only: the flip-flop stays set until the next tick
            SEQ_PULSE:
            begin
                if (st_ff.seq_cnt != 10'h0)
                    nxt_st.seq_cnt = st_ff.seq_cnt - 10'h1;
                else
                    nxt_st.seq = SEQ_IDLE;
            end
            // unused code: fall back to idle
            default:
            begin
                nxt_st.seq = SEQ_IDLE;
            end
        endcase

        // address reset wins over a tick in the same cycle
        // a running strobe is left to finish and then reads address 0
        if (btn_press[BTN_RST])
        begin
            // back to first count, memory kept
            nxt_st.addr    = '0;
            nxt_st.osc_cnt = '0;
        end

        // outputs, registered from the current state
        // so every output lags the state by one cycle: the relay
        // falls two cycles after the tick that clears the flip-flop
        // mark energises relay and lamp
        nxt_st.outs.keying_relay = st_ff.keying;
        nxt_st.outs.mark_lamp    = st_ff.keying;
        nxt_st.outs.space_lamp   = code_window & ~st_ff.keying;
        nxt_st.outs.error_lamp   = code_window & err_region
                                   & (err_enable | st_ff.entry_mode);
        nxt_st.outs.colocated_gate_relay = code_window;
    end

    // ****************************************
    // state register
    // ****************************************
    // reset loads constants only; the switches start in read mode
    // with the error region shut
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_ff            <= '0;
            st_ff.entry_mode <= CTRL_RESET[CTRL_ENTRY];
            st_ff.err_test   <= CTRL_RESET[CTRL_ERRTEST];
            st_ff.unrel_on   <= CTRL_RESET[CTRL_UNREL];
            st_ff.speed      <= KEY_PERIOD;
            st_ff.seq        <= SEQ_IDLE;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // every port comes straight from a flip-flop
    assign ahb_rsp.hreadyout = st_ff.hreadyout;
    assign ahb_rsp.hresp     = st_ff.hresp;
    assign ahb_rsp.hrdata    = st_ff.hrdata;
    assign key_out           = st_ff.outs;

endmodule

// [test/mik_keyer_chk.sv]
// port-level assertions for the ident keyer
`timescale 1ns/10ps
module mik_keyer_chk
    import mik_pkg::*;
#(
    parameter logic [SPEED_W-1:0] KEY_PERIOD = SPEED_W'(KEY_PERIOD_CYC),
    parameter logic [23:0]        SETTLE     = 24'(DEBOUNCE_CYC)
)
(
    input wire logic    hclk,
    input wire logic    hresetn,
    input mik_ahb_req_t ahb_req,
    input mik_ahb_rsp_t ahb_rsp,
    input wire logic    one_button,
    input wire logic    zero_button,
    input wire logic    address_reset_button,
    input wire logic    remote_fault,
    input mik_key_out_t key_out
);
    // debounce plus sync plus counter reset, with margin
    localparam int RST_MAX = int'(SETTLE) + 30;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    lamp_tracks_a: assert property (key_out.mark_lamp == key_out.keying_relay)
        else $error("mark lamp differs from relay");
    lamps_apart_a: assert property (!(key_out.mark_lamp && key_out.space_lamp))
        else $error("both lamps lit");
    space_on_zero_a: assert property (key_out.colocated_gate_relay |->
        key_out.space_lamp != key_out.keying_relay)
        else $error("space lamp wrong");
    mark_holds_a: assert property ($rose(key_out.keying_relay) |-> key_out.keying_relay [*8])
        else $error("mark too short");
    release_holds_a: assert property ($fell(key_out.keying_relay) |->
        !key_out.keying_relay [*8])
        else $error("relay set again too soon");
    gate_inhibits_a: assert property ((!key_out.colocated_gate_relay) [*2] |->
        !key_out.keying_relay)
        else $error("keying outside code period");
    error_window_a: assert property (key_out.error_lamp |-> key_out.colocated_gate_relay)
        else $error("error lamp outside window");
    reset_returns_a: assert property ($rose(address_reset_button) ##1
        address_reset_button [*8] |-> ##[1:RST_MAX] key_out.colocated_gate_relay)
        else $error("counter not reset");
    mark_seen_c: cover property ($rose(key_out.keying_relay));
    error_seen_c: cover property ($rose(key_out.error_lamp));
    fault_seen_c: cover property (remote_fault && key_out.error_lamp);
endmodule
bind mik_keyer mik_keyer_chk #(.KEY_PERIOD(KEY_PERIOD), .SETTLE(SETTLE)) u_chk (
    .hclk(hclk), .hresetn(hresetn), .ahb_req(ahb_req), .ahb_rsp(ahb_rsp),
    .one_button(one_button), .zero_button(zero_button),
    .address_reset_button(address_reset_button), .remote_fault(remote_fault),
    .key_out(key_out));

// [test/mik_operator.sv]
// operator model: presses the entry buttons
`timescale 1ns/10ps
module mik_operator
(
    input  wire logic hclk,
    output logic      one_button,
    output logic      zero_button,
    output logic      address_reset_button
);
    initial {one_button, zero_button, address_reset_button} = 3'h0;
    // held past settle time, then a whole strobe sequence waited out
    task automatic press(input int which);
        @(posedge hclk);
        one_button <= (which == 0);
        zero_button <= (which == 1);
        address_reset_button <= (which == 2);
        repeat (20) @(posedge hclk);
        {one_button, zero_button, address_reset_button} <= 3'h0;
        repeat (1100) @(posedge hclk);
    endtask
    task automatic send_char(input int ones);
        repeat (ones) press(0);
        press(1);
    endtask
    task automatic spaces();
        repeat (3) press(1);
    endtask
endmodule

// [test/test_mik_keyer.sv]
// self-checking bench for the ident keyer
`timescale 1ns/10ps
module test_mik_keyer
    import mik_pkg::*;
;
    localparam logic [SPEED_W-1:0] PERIOD = 24'h4b0; // short dot, 1200 cycles
    logic         hclk;
    logic         hresetn;
    logic         remote_fault;
    logic         one_b, zero_b, rst_b;
    mik_ahb_req_t req;
    mik_ahb_rsp_t rsp;
    mik_key_out_t kout;
    logic [31:0]  rd;
    int           bad_count;
    int           samples_checked;
    mik_keyer #(.KEY_PERIOD(PERIOD), .SETTLE(24'h8)) u_dut (.hclk(hclk), .hresetn(hresetn),
        .ahb_req({req.hsel, req.haddr, req.htrans, req.hwrite, req.hsize, rsp.hreadyout,
        req.hwdata}), .ahb_rsp(rsp), .one_button(one_b), .zero_button(zero_b),
        .address_reset_button(rst_b), .remote_fault(remote_fault), .key_out(kout));
    mik_operator u_op (.hclk(hclk), .one_button(one_b), .zero_button(zero_b),
        .address_reset_button(rst_b));
    initial
    begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    task automatic chk(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1)
        begin
            bad_count++;
            $display("unexpected %0t %s", $time, msg);
        end
    endtask
    // single transfer; hready waited on in both phases
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        req.hsel <= 1'b1;
        req.haddr <= {24'h0, a};
        req.htrans <= 2'h2;
        req.hwrite <= w;
        req.hsize <= 3'h2;
        do @(posedge hclk); while (rsp.hreadyout !== 1'b1);
        req.htrans <= 2'h0;
        req.hwdata <= d;
        do @(posedge hclk); while (rsp.hreadyout !== 1'b1);
        rd = rsp.hrdata;
    endtask
    task automatic wait_addr(input logic [7:0] a);
        int n;
        n = 0;
        do
        begin
            bus(1'b0, REG_STATUS, 32'h0);
            n++;
        end
        while (rd[7:0] !== a && n < 30000);
        chk(rd[7:0] === a, "address not reached");
    endtask
    task automatic t_regs();
        bus(1'b0, REG_SPEED, 32'h0);
        chk(rd[SPEED_W-1:0] === PERIOD, "speed reset");
        bus(1'b0, 8'h0c, 32'h0);
        chk(rd === 32'h0, "unmapped read");
        chk(rsp.hresp === 1'b0, "response not okay");
        bus(1'b1, REG_CTRL, 32'h1);
        bus(1'b0, REG_CTRL, 32'h0);
        chk(rd[2:0] === 3'h1, "ctrl readback");
    endtask
    // oscillator must stay still between presses
    task automatic t_entry();
        u_op.press(2);
        u_op.spaces();
        u_op.send_char(1);
        u_op.send_char(3);
        repeat (2500) @(posedge hclk);
        bus(1'b0, REG_STATUS, 32'h0);
        chk(rd[7:0] === 8'h9, "entry count");
    endtask
    task automatic t_read();
        logic [9:1] exp;
        exp = 9'h0e8;
        bus(1'b1, REG_CTRL, 32'h0);
        u_op.press(2);
        wait_addr(8'h1);
        repeat (700) @(posedge hclk);
        for (int i = 1; i <= 9; i++)
        begin
            chk(kout.keying_relay === exp[i], "keyed bit");
            repeat (1200) @(posedge hclk);
        end
    endtask
    // error region opened by fault, unreliability and test
    task automatic t_error();
        bus(1'b1, REG_SPEED, 32'h3e9);
        wait_addr(8'h31);
        chk(kout.error_lamp === 1'b0, "region shut");
        chk(kout.colocated_gate_relay === 1'b1, "gate in code");
        remote_fault <= 1'b1;
        repeat (3) @(posedge hclk);
        chk(kout.error_lamp === 1'b1, "fault opens");
        remote_fault <= 1'b0;
        bus(1'b1, REG_CTRL, 32'h4);
        repeat (3) @(posedge hclk);
        chk(kout.error_lamp === 1'b1, "unrel opens");
        bus(1'b1, REG_CTRL, 32'h2);
        repeat (3) @(posedge hclk);
        chk(kout.error_lamp === 1'b1, "test opens");
        bus(1'b1, REG_CTRL, 32'h0);
        repeat (3) @(posedge hclk);
        chk(kout.error_lamp === 1'b0, "ident only");
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        hresetn = 1'b0;
        remote_fault = 1'b0;
        req = '0;
        bad_count = 0;
        samples_checked = 0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        t_regs();
        t_entry();
        t_read();
        t_error();
        print_verdict();
    end
    // run needs about 66k cycles
    initial
    begin
        repeat (95000) @(posedge hclk);
        bad_count++;
        print_verdict();
    end
endmodule
